// ### src/chdiv_pkg.sv
// Summary of operation
// - The low phase lasts the low-count field plus one input cycles, and channel 0's field resets to 7.
// - The high phase lasts the high-count field plus one input cycles, and channel 0's field resets to 7.
// - Bypass stops the divider and passes the external clock straight to the divider output.
// - With ignore-sync clear the divider obeys the chip sync signal, and with it set the signal is disregarded.
// - Force drives the output low when clear or to the start level when set, and only while ignore-sync is set.
// - Force has no effect while bypassed, since bypass takes priority.
// - The start-level bit picks whether the divided clock starts low (0) or high (1).
// - A four-bit phase offset, in input cycles and resetting to zero, delays the output timing.
// - Channel power-down puts all three outputs of the channel into a safe off state.
// - Direct route sends the oscillator (select 10b) or the external clock (00b) to the outputs, and 01b does nothing.
// - Duty correction is on when its disable bit is 0 and off when it is 1.
// - Channel 1 uses the same low-count encoding as channel 0, and its field resets to 3.
// - Channel 1's high-count field resets to 3, giving four high cycles.
package chdiv_pkg;
  localparam logic [8:0] CHDIV_OFF_PHASE0 = 9'h190;
  localparam logic [8:0] CHDIV_OFF_CTRL0 = 9'h191;
  localparam logic [8:0] CHDIV_OFF_ROUTE0 = 9'h192;
  localparam logic [8:0] CHDIV_OFF_PHASE1 = 9'h193;
  localparam logic [7:0] CHDIV_RST_PHASE0 = 8'h77;
  localparam logic [7:0] CHDIV_RST_CTRL0 = 8'h00;
  localparam logic [7:0] CHDIV_RST_ROUTE0 = 8'h00;
  localparam logic [7:0] CHDIV_RST_PHASE1 = 8'h33;
  localparam logic [7:0] CHDIV_ROUTE_MASK = 8'h07;
  localparam logic [1:0] CHDIV_SRC_OSC = 2'h2;
  localparam logic [1:0] CHDIV_SRC_EXT = 2'h0;
  localparam int CHDIV_BIT_BYPASS = 7;
  localparam int CHDIV_BIT_IGNSYNC = 6;
  localparam int CHDIV_BIT_FORCE = 5;
  localparam int CHDIV_BIT_START = 4;
  localparam int CHDIV_BIT_PDOWN = 2;
  localparam int CHDIV_BIT_DIRECT = 1;
  localparam int CHDIV_BIT_NODCC = 0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } chdiv_req_s;

  typedef struct packed {
    logic [2:0] pins;
    logic [2:0] pins_en;
  } chdiv_out_s;

  typedef enum logic [1:0] {
    CHDIV_DELAY = 2'b00,
    CHDIV_LOW = 2'b01,
    CHDIV_HIGH = 2'b11
  } chdiv_state_e;
endpackage : chdiv_pkg

// ### src/chdiv_top.sv
`timescale 1ns/1ps
module chdiv_top
  import chdiv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire chdiv_pkg::chdiv_req_s req,
  input wire logic [1:0] src_select,
  input wire logic sync_n,
  input wire logic osc_level,
  input wire logic ext_level,
  output logic [7:0] rdata,
  output chdiv_pkg::chdiv_out_s outs,
  output logic div_out,
  output logic duty_correction,
  output logic ch1_low_count_dbg
);
  import chdiv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] phase0;
  logic [7:0] ctrl0;
  logic [7:0] route0;
  logic [7:0] phase1;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      phase0 <= CHDIV_RST_PHASE0;
      ctrl0 <= CHDIV_RST_CTRL0;
      route0 <= CHDIV_RST_ROUTE0;
      phase1 <= CHDIV_RST_PHASE1;
    end
    else if (req.wr)
    begin
      unique case (req.addr)
        CHDIV_OFF_PHASE0: phase0 <= req.wdata;
        CHDIV_OFF_CTRL0: ctrl0 <= req.wdata;
        CHDIV_OFF_ROUTE0: route0 <= req.wdata & CHDIV_ROUTE_MASK;
        CHDIV_OFF_PHASE1: phase1 <= req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rdata <= 8'h00;
    end
    else if (req.rd)
    begin
      unique case (req.addr)
        CHDIV_OFF_PHASE0: rdata <= phase0;
        CHDIV_OFF_CTRL0: rdata <= ctrl0;
        CHDIV_OFF_ROUTE0: rdata <= route0;
        CHDIV_OFF_PHASE1: rdata <= phase1;
        default: rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync input synchroniser and falling-edge detect
  logic sync_m;
  logic sync_s;
  logic sync_d;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sync_m <= 1'b1;
      sync_s <= 1'b1;
      sync_d <= 1'b1;
    end
    else
    begin
      sync_m <= sync_n;
      sync_s <= sync_m;
      sync_d <= sync_s;
    end
  end
  logic sync_evt;
  assign sync_evt = sync_d & ~sync_s & ~ctrl0[CHDIV_BIT_IGNSYNC];

  ////////////////////////////////////////////////////////////////////////////
  // divider counter
  chdiv_state_e state;
  logic [3:0] cnt;
  logic level;
  logic [3:0] low_n;
  logic [3:0] high_n;
  assign low_n = phase0[7:4];
  assign high_n = phase0[3:0];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || sync_evt)
    begin
      state <= CHDIV_DELAY;
      cnt <= ctrl0[3:0];
      level <= ctrl0[CHDIV_BIT_START];
    end
    else if (ctrl0[CHDIV_BIT_BYPASS])
    begin
      cnt <= 4'h0;
    end
    else
    begin
      unique case (state)
        CHDIV_DELAY:
        begin
          if (cnt == 4'h0)
          begin
            state <= level ? CHDIV_HIGH : CHDIV_LOW;
            cnt <= level ? high_n : low_n;
          end
          else
            cnt <= cnt - 4'h1;
        end
        CHDIV_LOW:
        begin
          if (cnt == 4'h0)
          begin
            state <= CHDIV_HIGH;
            level <= 1'b1;
            cnt <= high_n;
          end
          else
            cnt <= cnt - 4'h1;
        end
        CHDIV_HIGH:
        begin
          if (cnt == 4'h0)
          begin
            state <= CHDIV_LOW;
            level <= 1'b0;
            cnt <= low_n;
          end
          else
            cnt <= cnt - 4'h1;
        end
        default:
          state <= CHDIV_DELAY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output selection
  logic next_div;
  logic next_pin;
  always_comb
  begin
    if (ctrl0[CHDIV_BIT_BYPASS])
      next_div = ext_level;
    else if (ctrl0[CHDIV_BIT_IGNSYNC])
      next_div = ctrl0[CHDIV_BIT_FORCE] ? ctrl0[CHDIV_BIT_START] : 1'b0;
    else
      next_div = level;
    next_pin = next_div;
    if (route0[CHDIV_BIT_DIRECT])
    begin
      if (src_select == CHDIV_SRC_OSC)
        next_pin = osc_level;
      else if (src_select == CHDIV_SRC_EXT)
        next_pin = ext_level;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      div_out <= 1'b0;
      outs <= '0;
      duty_correction <= 1'b1;
      ch1_low_count_dbg <= 1'b0;
    end
    else
    begin
      div_out <= next_div;
      duty_correction <= ~route0[CHDIV_BIT_NODCC];
      ch1_low_count_dbg <= |phase1[7:4];
      if (route0[CHDIV_BIT_PDOWN])
        outs <= '0;
      else
        outs <= '{pins: {3{next_pin}}, pins_en: 3'b111};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_pdown_safe: assert property (@(posedge ref_clk) disable iff (!rst_n)
    route0[CHDIV_BIT_PDOWN] |=> outs == '0)
    else $error("power-down left outputs enabled");
  chk_dcc_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    route0[CHDIV_BIT_NODCC] |=> !duty_correction)
    else $error("duty correction not disabled");
  chk_force_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl0[CHDIV_BIT_IGNSYNC] && !ctrl0[CHDIV_BIT_FORCE] && !ctrl0[CHDIV_BIT_BYPASS] |=> !div_out)
    else $error("forced output not low");
  chk_sync_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sync_evt |=> state == CHDIV_DELAY && cnt == $past(ctrl0[3:0]))
    else $error("sync did not restart counter");
  chk_low_to_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == CHDIV_LOW && cnt == 4'h0 && !sync_evt && !ctrl0[CHDIV_BIT_BYPASS]
    |=> state == CHDIV_HIGH && cnt == $past(high_n))
    else $error("high phase load wrong");
  chk_high_to_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == CHDIV_HIGH && cnt == 4'h0 && !sync_evt && !ctrl0[CHDIV_BIT_BYPASS]
    |=> state == CHDIV_LOW && cnt == $past(low_n))
    else $error("low phase load wrong");
  chk_ignore_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl0[CHDIV_BIT_IGNSYNC] && sync_d && !sync_s && state != CHDIV_DELAY
    |=> state != CHDIV_DELAY)
    else $error("sync obeyed while ignored");
  chk_direct_osc: assert property (@(posedge ref_clk) disable iff (!rst_n)
    route0[CHDIV_BIT_DIRECT] && !route0[CHDIV_BIT_PDOWN] && src_select == CHDIV_SRC_OSC
    |=> outs.pins == {3{$past(osc_level)}})
    else $error("oscillator not routed");
  chk_bypass_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl0[CHDIV_BIT_BYPASS] |=> div_out == $past(ext_level))
    else $error("bypass output does not follow input");
endmodule : chdiv_top

// ### tb/chdiv_top_tb.sv
`timescale 1ns/1ps
module chdiv_top_tb;
  import chdiv_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  chdiv_req_s req = '0;
  logic [1:0] src_select = 2'h0;
  logic sync_n = 1'b1;
  logic osc_level = 1'b0;
  logic ext_level = 1'b0;
  logic [7:0] rdata;
  chdiv_out_s outs;
  logic div_out;
  logic duty_correction;
  logic ch1_low_count_dbg;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int k, t0, t1;
  logic [7:0] v;
  logic [7:0] wd;
  logic [3:0] lo, hi, o1, o2;
  logic [8:0] ra [5] = '{9'h190, 9'h191, 9'h192, 9'h193, 9'h1ff};
  logic [7:0] rv [5] = '{8'h77, 8'h00, 8'h00, 8'h33, 8'h00};
  chdiv_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .src_select(src_select),
    .sync_n(sync_n), .osc_level(osc_level), .ext_level(ext_level), .rdata(rdata),
    .outs(outs), .div_out(div_out), .duty_correction(duty_correction),
    .ch1_low_count_dbg(ch1_low_count_dbg));
  always #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // expected readback of a written byte: masked route register, zero when unmapped
  function automatic logic [7:0] reg_exp(input logic [8:0] a, input logic [7:0] d);
    if (a == CHDIV_OFF_ROUTE0)
      return d & CHDIV_ROUTE_MASK;
    else if (a == CHDIV_OFF_PHASE0 || a == CHDIV_OFF_CTRL0 || a == CHDIV_OFF_PHASE1)
      return d;
    else
      return 8'h00;
  endfunction : reg_exp
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    req = '0;
    repeat (2) @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    req = '0;
    @(negedge ref_clk);
    d = rdata;
  endtask : rd
  task automatic wait_lvl(input logic l);
    int n;
    n = 0;
    while (div_out !== l && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 100)
      check(8'h00, 8'h01, "divider level wait");
  endtask : wait_lvl
  // restart by sync, return cycles until the start phase ends
  task automatic sync_lat(input logic s, output int t);
    @(negedge ref_clk);
    sync_n = 1'b0;
    t = cyc;
    repeat (5) @(negedge ref_clk);
    sync_n = 1'b1;
    wait_lvl(s);
    wait_lvl(!s);
    t = cyc - t;
  endtask : sync_lat
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    v = 8'($urandom(32'h1e6d_92a4));
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    for (k = 0; k < 5; k++)
    begin
      rd(ra[k], v);
      check(v, rv[k], "reset value");
    end
    for (k = 0; k < 5; k++)
    begin
      wd = k == 2 ? 8'hff : 8'($urandom);
      wr(ra[k], wd);
      rd(ra[k], v);
      check(v, reg_exp(ra[k], wd), "readback");
    end
    wr(9'h193, 8'h0f);
    check(8'(ch1_low_count_dbg), 8'h00, "ch1 low zero");
    wr(9'h193, 8'h40);
    check(8'(ch1_low_count_dbg), 8'h01, "ch1 low set");
    wr(9'h192, 8'h00);
    wr(9'h191, 8'h00);
    for (k = 0; k < 6; k++)
    begin
      lo = k == 0 ? 4'h0 : (k == 1 ? 4'hf : 4'($urandom_range(15)));
      hi = k == 0 ? 4'h0 : (k == 1 ? 4'hf : 4'($urandom_range(15)));
      wr(9'h190, {lo, hi});
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      t0 = cyc;
      wait_lvl(1'b1);
      t1 = cyc;
      wait_lvl(1'b0);
      check(8'(t1 - t0), 8'(lo + 1), "low phase");
      check(8'(cyc - t1), 8'(hi + 1), "high phase");
    end
    wr(9'h190, 8'h52);
    for (k = 0; k < 2; k++)
    begin
      o1 = 4'($urandom_range(15));
      o2 = 4'($urandom_range(15));
      wr(9'h191, {3'h0, k[0], o1});
      sync_lat(k[0], t0);
      wr(9'h191, {3'h0, k[0], o2});
      sync_lat(k[0], t1);
      check(8'(t1 - t0), 8'(o2 - o1), "offset delay");
      t0 = cyc;
      wait_lvl(k[0]);
      check(8'(cyc - t0), k[0] ? 8'h06 : 8'h03, "phase after start");
    end
    for (k = 0; k < 4; k++)
    begin
      wr(9'h191, {2'b01, k[1], k[0], 4'h0});
      sync_n = 1'b0;
      repeat (8)
      begin
        @(negedge ref_clk);
        check(8'(div_out), 8'(k[1] & k[0]), "forced level");
      end
      sync_n = 1'b1;
    end
    for (k = 0; k < 2; k++)
    begin
      wr(9'h191, k[0] ? 8'hf0 : 8'h80);
      repeat (10)
      begin
        ext_level = 1'($urandom);
        @(negedge ref_clk);
        check(8'(div_out), 8'(ext_level), "bypass follow");
        check(8'(outs.pins), 8'({3{ext_level}}), "pins follow divider");
      end
    end
    wr(9'h191, 8'h00);
    wr(9'h192, 8'h02);
    for (k = 0; k < 3; k++)
    begin
      src_select = k == 0 ? 2'h2 : (k == 1 ? 2'h0 : 2'h1);
      repeat (10)
      begin
        osc_level = 1'($urandom);
        ext_level = ~osc_level;
        @(negedge ref_clk);
        if (k < 2)
          check(8'(outs.pins), 8'({3{k == 0 ? osc_level : ext_level}}), "direct route");
        else
          check(8'(outs.pins), 8'({3{div_out}}), "route no effect");
      end
    end
    check(8'(outs.pins_en), 8'h07, "outputs on");
    wr(9'h192, 8'h04);
    check(8'(outs), 8'h00, "power down");
    check(8'(duty_correction), 8'h01, "duty on");
    wr(9'h192, 8'h01);
    check(8'(duty_correction), 8'h00, "duty off");
    check(8'(outs.pins_en), 8'h07, "power restored");
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(8'(outs), 8'h00, "outputs in reset");
    check(8'(duty_correction), 8'h01, "duty in reset");
    rst_n = 1'b1;
    for (k = 0; k < 5; k++)
    begin
      rd(ra[k], v);
      check(v, rv[k], "reset value again");
    end
    test_done();
  end
endmodule : chdiv_top_tb
